// ==== src/mcc_defs.vh ====
// constants for the machine counter and trap register bank
`ifndef MCC_DEFS_VH
`define MCC_DEFS_VH

// register index values on the csr_addr port (12-bit register numbers)
`define MCC_A_CYCLE 12'hc00
`define MCC_A_TIME 12'hc01
`define MCC_A_INSTRET 12'hc02
`define MCC_A_CYCLEH 12'hc80
`define MCC_A_TIMEH 12'hc81
`define MCC_A_INSTRETH 12'hc82
`define MCC_A_MCYCLE 12'hb00
`define MCC_A_MINSTRET 12'hb02
`define MCC_A_MCYCLEH 12'hb80
`define MCC_A_MINSTRETH 12'hb82
`define MCC_A_HCEN 12'h320
`define MCC_A_SCEN 12'h321
`define MCC_A_UCEN 12'h322
`define MCC_A_EVSEL 12'h320
`define MCC_A_SCRATCH 12'h340
`define MCC_A_EPC 12'h341
`define MCC_A_CAUSE 12'h342
// low five bits of a counter address select the counter
`define MCC_A_VIEW_HI 12'hc80
`define MCC_A_VIEW_LO 12'hc00
`define MCC_A_MCNT_LO 12'hb00
`define MCC_A_MCNT_HI 12'hb80
`define MCC_IDX_MASK 12'hfe0

// privilege mode encodings
`define MCC_PRV_U 2'h0
`define MCC_PRV_S 2'h1
`define MCC_PRV_H 2'h2
`define MCC_PRV_M 2'h3

// counter indices and enable bit positions
`define MCC_IDX_CYCLE 0
`define MCC_IDX_TIME 1
`define MCC_IDX_INSTRET 2
`define MCC_FIRST_EVENT 3
`define MCC_LAST_EVENT 31

// cause code for illegal instruction
`define MCC_CAUSE_ILLEGAL 2

// reset values
`define MCC_RST_CEN 32'h0000_0000
`define MCC_CNT_W 64

`endif

// ==== src/mcc_csr_bank.v ====
// machine counter, counter-enable, scratch, epc and cause registers
//
// Notes on behaviour
// - machine cycle counter, 64 bits, advances every hart cycle
// - retired counter, 64 bits, advances per retired instruction
// - 29 event counters 3..31, each with an event selector
// - selector value zero never advances its counter
// - unimplemented event counters and selectors are tied to zero
// - 32-bit width: low register gives bits 31:0, high gives 63:32
// - 128-bit width: counter reads sign-extend the 64-bit value
// - three 32-bit enables: bit0 cycle, 1 time, 2 retired, 3-31 events
// - hypervisor-mode view read with enable bit clear traps illegal
// - supervisor and user enables gate their modes the same way
// - enables always exist; masked bits read zero and trap in every mode below machine
// - unprivileged views are read-only; all but time copy machine counters
// - time view copies wall-clock input; enable bit may be tied zero
// - scratch register is free read/write, no side effects
// - epc never holds a misaligned program counter
// - trap loads epc with the faulting instruction's address
// - cause top bit set for interrupt traps, clear otherwise
// - cause low bits hold any cause_w-bit code written or trapped, unfiltered
// - insufficient privilege reported with illegal-instruction code
// - wall-clock input is a constant-rate 64-bit count
`include "mcc_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module mcc_csr_bank #(
	parameter base_register_width = 32,
	parameter has_compressed = 1,
	parameter [31:0] event_impl_mask = 32'hffff_fff8,
	parameter [31:0] cen_impl_mask = 32'hffff_ffff,
	parameter sel_w = 8,
	parameter cause_w = 4
) (
	// clock and reset
	input wire clock,
	input wire sys_rst,
	// register instruction port
	input wire csr_read,
	input wire csr_write,
	input wire [11:0] csr_addr,
	input wire [base_register_width-1:0] csr_wdata,
	input wire [1:0] priv_mode,
	output reg [base_register_width-1:0] csr_rdata,
	output reg csr_illegal,
	// pipeline events
	input wire instr_retired,
	input wire [31:0] platform_events,
	input wire [63:0] wall_clock,
	// trap entry
	input wire trap_take,
	input wire trap_interrupt,
	input wire [cause_w-1:0] trap_code,
	input wire [base_register_width-1:0] trap_pc,
	// trap state out
	output reg [base_register_width-1:0] epc_out,
	output reg [base_register_width-1:0] cause_out
);

localparam W = base_register_width;
localparam [W-1:0] epc_mask = has_compressed ? {{(W-1){1'b1}}, 1'b0} : {{(W-2){1'b1}}, 2'b00};

////////////////////////////////////////////////////////////////////////////////
// storage
// each counter and selector has one driver, inside its own generate slice
wire [63:0] cnt [0:31];
wire [sel_w-1:0] evsel [0:31];
// write data zero-extended so every base width slices it the same way
reg [127:0] wdata_wide;
always @* begin
	wdata_wide = 128'h0;
	wdata_wide[W-1:0] = csr_wdata;
end
reg [31:0] hcen;
reg [31:0] scen;
reg [31:0] ucen;
reg [W-1:0] scratch;
reg [W-1:0] epc;
reg cause_irq;
reg [cause_w-1:0] cause_code;

// decoded address fields
wire [4:0] idx = csr_addr[4:0];
wire [11:0] grp = csr_addr & `MCC_IDX_MASK;
wire is_view_lo = (grp == `MCC_A_VIEW_LO);
wire is_view_hi = (grp == `MCC_A_VIEW_HI) && (W == 32);
wire is_mcnt_lo = (grp == `MCC_A_MCNT_LO) && (idx != 5'h01);
wire is_mcnt_hi = (grp == `MCC_A_MCNT_HI) && (W == 32) && (idx != 5'h01);
wire is_evsel = (grp == `MCC_A_EVSEL) && (idx >= 5'h03);

////////////////////////////////////////////////////////////////////////////////
// counters
genvar g;
generate
	for (g = 0; g < 32; g = g + 1) begin : g_cnt
		wire hit_lo = csr_write && is_mcnt_lo && (idx == g);
		wire hit_hi = csr_write && is_mcnt_hi && (idx == g);
		wire tick;
		wire impl;
		reg [63:0] c;
		reg [sel_w-1:0] s;
		assign cnt[g] = c;
		assign evsel[g] = s;
		if (g == `MCC_IDX_CYCLE) begin : g_cy
			assign tick = 1'b1;
			assign impl = 1'b1;
		end else if (g == `MCC_IDX_INSTRET) begin : g_ir
			assign tick = instr_retired;
			assign impl = 1'b1;
		end else if (g == `MCC_IDX_TIME) begin : g_tm
			assign tick = 1'b0;
			assign impl = 1'b0;
		end else begin : g_ev
			// selector picks a platform event, zero means none
			assign tick = (evsel[g] != {sel_w{1'b0}}) &&
				platform_events[evsel[g][4:0]];
			assign impl = event_impl_mask[g];
		end
		always @(posedge clock or posedge sys_rst) begin
			if (sys_rst) begin
				c <= 64'h0;
			end else if (!impl) begin
				c <= 64'h0;
			end else if (hit_lo) begin
				// write replaces value; next count starts from it
				if (W == 32)
					c <= {c[63:32], wdata_wide[31:0]};
				else
					c <= wdata_wide[63:0];
			end else if (hit_hi) begin
				c <= {wdata_wide[31:0], c[31:0]};
			end else if (tick) begin
				c <= c + 64'h1; // natural wrap to zero
			end
		end
		always @(posedge clock or posedge sys_rst) begin
			if (sys_rst)
				s <= {sel_w{1'b0}};
			else if (!impl || g < `MCC_FIRST_EVENT)
				s <= {sel_w{1'b0}};
			else if (csr_write && is_evsel && idx == g)
				s <= wdata_wide[sel_w-1:0];
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// counter-enable, scratch, epc and cause
always @(posedge clock or posedge sys_rst) begin
	if (sys_rst) begin
		hcen <= `MCC_RST_CEN;
		scen <= `MCC_RST_CEN;
		ucen <= `MCC_RST_CEN;
		scratch <= {W{1'b0}};
		epc <= {W{1'b0}};
		cause_irq <= 1'b0;
		cause_code <= {cause_w{1'b0}};
	end else begin
		// tied bits stay zero so that mode always traps
		if (csr_write && csr_addr == `MCC_A_HCEN)
			hcen <= csr_wdata[31:0] & cen_impl_mask;
		if (csr_write && csr_addr == `MCC_A_SCEN)
			scen <= csr_wdata[31:0] & cen_impl_mask;
		if (csr_write && csr_addr == `MCC_A_UCEN)
			ucen <= csr_wdata[31:0] & cen_impl_mask;
		if (csr_write && csr_addr == `MCC_A_SCRATCH)
			scratch <= csr_wdata;
		// trap entry beats a software write in the same cycle
		if (trap_take) begin
			epc <= trap_pc & epc_mask;
			cause_irq <= trap_interrupt;
			cause_code <= trap_code;
		end else begin
			if (csr_write && csr_addr == `MCC_A_EPC)
				epc <= csr_wdata & epc_mask;
			if (csr_write && csr_addr == `MCC_A_CAUSE) begin
				cause_irq <= csr_wdata[W-1];
				cause_code <= csr_wdata[cause_w-1:0];
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// read mux and privilege check
reg [W-1:0] next_rdata;
reg next_illegal;
reg [63:0] view64;
reg [31:0] cen;
reg [127:0] wide;
always @* begin
	next_rdata = {W{1'b0}};
	next_illegal = 1'b0;
	wide = 128'h0; // widest base width; sliced down to W
	view64 = (idx == `MCC_IDX_TIME) ? wall_clock : cnt[idx];
	case (priv_mode)
		`MCC_PRV_H: cen = hcen;
		`MCC_PRV_S: cen = scen;
		`MCC_PRV_U: cen = ucen;
		default: cen = 32'hffff_ffff; // machine mode ungated
	endcase
	if (is_view_lo || is_view_hi) begin
		// views are read-only: a write traps too
		if (!cen[idx] || csr_write)
			next_illegal = 1'b1;
		else if (is_view_hi)
			next_rdata = view64[63:32];
		else if (W == 32)
			next_rdata = view64[31:0];
		else begin
			wide = {{64{view64[63]}}, view64};
			next_rdata = wide[W-1:0];
		end
	end else if (priv_mode != `MCC_PRV_M) begin
		next_illegal = 1'b1; // machine registers need machine mode
	end else if (is_mcnt_hi) begin
		next_rdata = cnt[idx][63:32];
	end else if (is_mcnt_lo) begin
		if (W == 32)
			next_rdata = cnt[idx][31:0];
		else begin
			wide = {{64{cnt[idx][63]}}, cnt[idx]};
			next_rdata = wide[W-1:0];
		end
	end else if (is_evsel) begin
		next_rdata = {{(W-sel_w){1'b0}}, evsel[idx]};
	end else begin
		case (csr_addr)
			`MCC_A_HCEN: begin
				wide = {96'h0, hcen};
				next_rdata = wide[W-1:0];
			end
			`MCC_A_SCEN: begin
				wide = {96'h0, scen};
				next_rdata = wide[W-1:0];
			end
			`MCC_A_UCEN: begin
				wide = {96'h0, ucen};
				next_rdata = wide[W-1:0];
			end
			`MCC_A_SCRATCH: next_rdata = scratch;
			`MCC_A_EPC: next_rdata = epc;
			`MCC_A_CAUSE: next_rdata = {cause_irq, {(W-1-cause_w){1'b0}}, cause_code};
			default: next_illegal = 1'b1; // unmapped address
		endcase
	end
	if (!csr_read && !csr_write) begin
		next_rdata = {W{1'b0}};
		next_illegal = 1'b0;
	end
end

// registered answer one cycle after the request
always @(posedge clock or posedge sys_rst) begin
	if (sys_rst) begin
		csr_rdata <= {W{1'b0}};
		csr_illegal <= 1'b0;
		epc_out <= {W{1'b0}};
		cause_out <= {W{1'b0}};
	end else begin
		csr_rdata <= next_rdata;
		csr_illegal <= next_illegal;
		epc_out <= epc;
		cause_out <= {cause_irq, {(W-1-cause_w){1'b0}}, cause_code};
	end
end

endmodule // mcc_csr_bank
`default_nettype wire

// ==== verif/mcc_csr_props.sv ====
// port assertions for the counter and trap register bank
`timescale 1ns/1ps
`default_nettype none
`include "mcc_defs.vh"
module mcc_csr_props #(
	parameter base_register_width = 32,
	parameter cause_w = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// register port
	input wire logic csr_read,
	input wire logic csr_write,
	input wire logic [11:0] csr_addr,
	input wire logic [1:0] priv_mode,
	input wire logic csr_illegal,
	input wire logic [base_register_width-1:0] csr_rdata,
	// trap side
	input wire logic trap_take,
	input wire logic trap_interrupt,
	input wire logic [cause_w-1:0] trap_code,
	input wire logic [base_register_width-1:0] trap_pc,
	input wire logic [base_register_width-1:0] epc_out,
	input wire logic [base_register_width-1:0] cause_out
);
	localparam logic [base_register_width-1:0] lsb_clear = ~1;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// plain machine read of the low cycle half
	wire logic rd_cyc = csr_read && !csr_write && csr_addr == `MCC_A_MCYCLE
		&& priv_mode == `MCC_PRV_M;
	cycle_step_a: assert property (
		rd_cyc ##1 rd_cyc |=> csr_rdata == $past(csr_rdata) + 1'b1) else $error("cycle step");
	view_ro_a: assert property (
		csr_write && csr_addr[11:8] == 4'hc |=> csr_illegal) else $error("view write");
	mach_ungated_a: assert property (
		csr_read && !csr_write && priv_mode == `MCC_PRV_M && csr_addr[11:5] == 7'h60
		|=> !csr_illegal) else $error("machine view gated");
	priv_refuse_a: assert property (
		csr_read && !csr_write && priv_mode != `MCC_PRV_M && csr_addr[11:8] == 4'h3
		|=> csr_illegal) else $error("machine reg open");
	epc_align_a: assert property (epc_out[0] == 1'b0) else $error("epc odd");
	trap_epc_a: assert property (
		trap_take ##1 !csr_write |=> epc_out == ($past(trap_pc, 2) & lsb_clear))
		else $error("epc load");
	trap_irq_a: assert property (
		trap_take ##1 !csr_write |-> ##1 cause_out[base_register_width-1] ==
		$past(trap_interrupt, 2)) else $error("cause top bit");
	trap_code_a: assert property (
		trap_take ##1 !csr_write |=> cause_out[cause_w-1:0] == $past(trap_code, 2))
		else $error("cause code");
	cover property (rd_cyc ##1 rd_cyc);
	cover property (trap_take ##2 cause_out[base_register_width-1]);
	cover property (csr_illegal);
endmodule // mcc_csr_props
bind mcc_csr_bank mcc_csr_props #(.base_register_width(base_register_width),
	.cause_w(cause_w)) i_mcc_csr_props (.clock, .sys_rst, .csr_read, .csr_write,
	.csr_addr, .priv_mode, .csr_illegal, .csr_rdata, .trap_take, .trap_interrupt,
	.trap_code, .trap_pc, .epc_out, .cause_out);
`default_nettype wire

// ==== verif/mcc_hart_model.sv ====
// pipeline model: retire pulses, platform events, wall clock
`timescale 1ns/1ps
`default_nettype none
module mcc_hart_model (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// pipeline side
	output var logic instr_retired = 1'b0,
	output var logic [31:0] platform_events = 32'h0,
	output logic [63:0] wall_clock
);
	// fixed rate, one tick per core cycle
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			wall_clock <= 64'h0;
		else
			wall_clock <= wall_clock + 64'h1;
	end
	// n back-to-back retires, each with event bit b, moved at falling edges
	task automatic pulse(input int n, input int b);
		repeat (n) begin
			@(negedge clock);
			instr_retired = 1'b1;
			platform_events = 32'h1 << b;
		end
		@(negedge clock);
		instr_retired = 1'b0;
		platform_events = 32'h0;
	endtask
endmodule // mcc_hart_model
`default_nettype wire

// ==== verif/mcc_csr_bank_tb_top.sv ====
// self-checking bench for the counter and trap register bank
`timescale 1ns/1ps
`default_nettype none
`include "mcc_defs.vh"
module mcc_csr_bank_tb_top;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic csr_read = 1'b0;
	logic csr_write = 1'b0;
	logic [11:0] csr_addr = 12'h0;
	logic [31:0] csr_wdata = 32'h0;
	logic [1:0] priv_mode = 2'h3;
	logic trap_take = 1'b0;
	logic trap_interrupt = 1'b0;
	logic [3:0] trap_code = 4'h0;
	logic [31:0] trap_pc = 32'h0;
	logic [31:0] rd;
	logic ill;
	wire logic [31:0] csr_rdata, epc_out, cause_out, platform_events;
	wire logic csr_illegal, instr_retired;
	wire logic [63:0] wall_clock;
	int mismatches = 0;
	int checks_done = 0;
	always #25 clock = ~clock;
	mcc_csr_bank i_mcc_csr_bank (.clock, .sys_rst, .csr_read, .csr_write, .csr_addr,
		.csr_wdata, .priv_mode, .csr_rdata, .csr_illegal, .instr_retired, .platform_events,
		.wall_clock, .trap_take, .trap_interrupt, .trap_code, .trap_pc, .epc_out, .cause_out);
	mcc_hart_model i_mcc_hart_model (.clock, .sys_rst, .instr_retired, .platform_events,
		.wall_clock);
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// one request, answer taken one cycle later
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] p);
		@(negedge clock);
		{csr_read, csr_write, csr_addr, csr_wdata, priv_mode} = {!w, w, a, d, p};
		@(negedge clock);
		{csr_read, csr_write} = 2'b00;
		rd = csr_rdata;
		ill = csr_illegal;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [1:0] p, input logic [31:0] e,
		input logic i);
		acc(1'b0, a, 32'h0, p);
		check(rd, e);
		check({31'h0, ill}, {31'h0, i});
	endtask
	task automatic conclude;
		if (mismatches == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		#100us;
		mismatches++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'b0;
		for (int a = 0; a < 3; a++) rdchk(12'(12'h320 + a), 2'h3, 32'h0, 1'b0);
		acc(1'b1, `MCC_A_SCRATCH, 32'hdead_beef, `MCC_PRV_M);
		rdchk(`MCC_A_SCRATCH, `MCC_PRV_M, 32'hdead_beef, 1'b0);
		acc(1'b1, `MCC_A_EPC, 32'h0000_1235, `MCC_PRV_M);
		rdchk(`MCC_A_EPC, `MCC_PRV_M, 32'h0000_1234, 1'b0);
		// each lower mode traps until its own enable opens cycle and retired views
		for (int m = 0; m < 3; m++) begin
			rdchk(`MCC_A_CYCLE, 2'(m), 32'h0, 1'b1);
			acc(1'b1, 12'(12'h322 - m), 32'h0000_0005, `MCC_PRV_M);
			rdchk(`MCC_A_TIME, 2'(m), 32'h0, 1'b1);
			acc(1'b0, `MCC_A_CYCLE, 32'h0, 2'(m));
			check({31'h0, ill}, 32'h0);
		end
		acc(1'b0, `MCC_A_TIME, 32'h0, `MCC_PRV_M);
		check({31'h0, ill}, 32'h0);
		check(rd, wall_clock[31:0] - 32'h1);
		rdchk(`MCC_A_SCRATCH, `MCC_PRV_U, 32'h0, 1'b1);
		rdchk(12'h7ff, `MCC_PRV_M, 32'h0, 1'b1);
		acc(1'b1, `MCC_A_CYCLE, 32'h1, `MCC_PRV_M);
		check({31'h0, ill}, 32'h1);
		// back-to-back cycle reads step by one
		@(negedge clock);
		{csr_read, csr_addr, priv_mode} = {1'b1, `MCC_A_MCYCLE, `MCC_PRV_M};
		@(negedge clock);
		rd = csr_rdata;
		@(negedge clock);
		csr_read = 1'b0;
		check(csr_rdata, rd + 32'h1);
		acc(1'b1, `MCC_A_MCYCLEH, 32'h0, `MCC_PRV_M);
		acc(1'b1, `MCC_A_MCYCLE, 32'hffff_fff0, `MCC_PRV_M);
		repeat (20) @(negedge clock);
		rdchk(`MCC_A_MCYCLEH, `MCC_PRV_M, 32'h1, 1'b0);
		acc(1'b1, 12'h323, 32'h5, `MCC_PRV_M);
		i_mcc_hart_model.pulse(4, 5);
		i_mcc_hart_model.pulse(3, 0);
		rdchk(12'h323, `MCC_PRV_M, 32'h5, 1'b0);
		rdchk(12'hb03, `MCC_PRV_M, 32'h4, 1'b0);
		rdchk(12'hb04, `MCC_PRV_M, 32'h0, 1'b0);
		rdchk(`MCC_A_MINSTRET, `MCC_PRV_M, 32'h7, 1'b0);
		rdchk(`MCC_A_INSTRET, `MCC_PRV_U, 32'h7, 1'b0);
		// an exception then an interrupt trap
		for (int i = 0; i < 2; i++) begin
			@(negedge clock);
			{trap_take, trap_interrupt} = {1'b1, 1'(i)};
			{trap_code, trap_pc} = {i ? 4'h7 : 4'h2, i ? 32'h0000_2000 : 32'h0000_1002};
			@(negedge clock);
			trap_take = 1'b0;
			@(negedge clock);
			check(epc_out, trap_pc);
			check(cause_out, {1'(i), 27'h0, trap_code});
		end
		rdchk(`MCC_A_CAUSE, `MCC_PRV_M, 32'h8000_0007, 1'b0);
		conclude();
	end
endmodule // mcc_csr_bank_tb_top
`default_nettype wire
